/* File: src/vfd_display_controller.sv */
`timescale 1ns/1ps
module vfd_display_controller
  import vfd_pkg::*;
(
  // Clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        reset,
  // Straps, active low
  input  wire logic                        pattern_sel_a_n,
  input  wire logic                        pattern_sel_b_n,
  // Host clock and command link
  input  wire logic                        host_display_clock,
  input  wire logic                        host_cmd_data,
  input  wire logic                        host_cmd_clock,
  output logic                             ctrl_rx_ready,
  output logic                             controller_clock_half,
  output vfd_pkg::cmd_type                 cmd_out,
  // Display drive
  output vfd_pkg::panel_drive_type         panel_out,
  output logic                             beeper,
  // Key scan lines
  input  wire logic [SCAN_LINES-1:0]       key_scan_line,
  output logic [SCAN_LINES-1:0]            key_pressed
);
  import vfd_pkg::*;

  typedef struct packed {
    logic [1:0]             sa_sync;
    logic [1:0]             sb_sync;
    logic [2:0]             hclk_sync;
    logic [2:0]             cclk_sync;
    logic [1:0]             cdat_sync;
    logic [SCAN_LINES-1:0]  key_s1;
    logic [SCAN_LINES-1:0]  key_s2;
    state_type              state;
    pattern_type            pattern;
    logic [ADDR_W-1:0]      addr;
    logic [ADDR_W-1:0]      scan_idx;
    logic [15:0]            dwell;
    logic [31:0]            beep_cnt;
    logic [2:0]             bit_cnt;
    logic [7:0]             shift;
    logic                   half_clk;
    logic                   ready_n;
    cmd_type                cmd;
    panel_drive_type        drive;
    logic                   beep;
    logic [SCAN_LINES-1:0]  keys;
  } state_all_type;

  state_all_type st_r;
  state_all_type st_nxt;
  logic [ANODE_COUNT-1:0] disp_mem [GRID_COUNT];
  logic                   mem_we;
  logic [ANODE_COUNT-1:0] mem_wdata;

  // Pattern word for one grid position
  function automatic logic [ANODE_COUNT-1:0] pattern_word(
    input pattern_type p,
    input logic [ADDR_W-1:0] a
  );
    case (p)
      PAT_ALL_OFF: pattern_word = ANODE_ALL_OFF;
      PAT_ALL_ON:  pattern_word = ANODE_ALL_ON;
      PAT_TEST1:   pattern_word = a[0] ? TEST1_ODD : TEST1_EVEN;
      PAT_TEST2:   pattern_word = a[0] ? TEST2_ODD : TEST2_EVEN;
      default:     pattern_word = ANODE_ALL_ON;
    endcase
  endfunction : pattern_word

  // Next-state logic
  always_comb
  begin
    st_nxt = st_r;
    mem_we = 1'b0;
    mem_wdata = '0;
    // Pins come from outside; two flops before any use
    st_nxt.sa_sync   = {st_r.sa_sync[0], pattern_sel_a_n};
    st_nxt.sb_sync   = {st_r.sb_sync[0], pattern_sel_b_n};
    st_nxt.hclk_sync = {st_r.hclk_sync[1:0], host_display_clock};
    st_nxt.cclk_sync = {st_r.cclk_sync[1:0], host_cmd_clock};
    st_nxt.cdat_sync = {st_r.cdat_sync[0], host_cmd_data};
    st_nxt.key_s1    = key_scan_line;
    st_nxt.key_s2    = st_r.key_s1;
    // Closed key pulls its line low; idle lines read high
    st_nxt.keys      = ~st_r.key_s2;
    st_nxt.cmd.valid = 1'b0;

    // Halve on each rising host clock edge; only the second and third
    // stages feed the edge detector. Ignored while the stages still
    // hold reset zeros, so a high host clock gives no false edge
    if (st_r.hclk_sync[1] && !st_r.hclk_sync[2] &&
        st_r.state != ST_STRAP)
      st_nxt.half_clk = ~st_r.half_clk;

    case (st_r.state)
      ST_STRAP:
      begin
        // Decode waits until the strap synchroniser has filled
        if (st_r.addr == 4'h2)
        begin
          case ({st_r.sa_sync[1], st_r.sb_sync[1]})
            2'b11:   st_nxt.pattern = PAT_ALL_OFF;
            2'b10:   st_nxt.pattern = PAT_ALL_ON;
            2'b01:   st_nxt.pattern = PAT_TEST1;
            default: st_nxt.pattern = PAT_TEST2;
          endcase
          if (!(st_r.sa_sync[1] && !st_r.sb_sync[1]) &&
              !(st_r.sa_sync[1] && st_r.sb_sync[1]))
          begin
            st_nxt.beep = 1'b1;
            st_nxt.beep_cnt = 32'(BEEP_CYC);
          end
          st_nxt.addr  = '0;
          st_nxt.state = ST_FILL;
        end
        else
          st_nxt.addr = st_r.addr + 4'h1;
      end
      ST_FILL:
      begin
        mem_we = 1'b1;
        mem_wdata = pattern_word(st_r.pattern, st_r.addr);
        if (st_r.addr == 4'(GRID_COUNT - 1))
          st_nxt.state = ST_READY;
        else
          st_nxt.addr = st_r.addr + 4'h1;
      end
      ST_READY:
      begin
        // Reached only after reset has been released
        st_nxt.ready_n = 1'b0;
        st_nxt.state = ST_IDLE;
      end
      ST_IDLE:
      begin
        // Rising command clock samples data, MSB first
        if (st_r.cclk_sync[1] && !st_r.cclk_sync[2])
        begin
          st_nxt.shift = {st_r.shift[6:0], st_r.cdat_sync[1]};
          st_nxt.bit_cnt = st_r.bit_cnt + 3'h1;
          if (st_r.bit_cnt == 3'h7)
          begin
            st_nxt.cmd.valid = 1'b1;
            st_nxt.cmd.data = {st_r.shift[6:0], st_r.cdat_sync[1]};
          end
        end
      end
      default: st_nxt.state = ST_STRAP;
    endcase

    // Beeper times out on its own
    if (st_r.beep)
    begin
      if (st_r.beep_cnt == '0)
        st_nxt.beep = 1'b0;
      else
        st_nxt.beep_cnt = st_r.beep_cnt - 32'h1;
    end

    // Cyclic grid scan; one grid high at a time with its anodes
    if (st_r.state == ST_IDLE || st_r.state == ST_READY)
    begin
      if (st_r.dwell == 16'(GRID_DWELL_CYC - 1))
      begin
        st_nxt.dwell = '0;
        st_nxt.scan_idx = (st_r.scan_idx == 4'(GRID_COUNT - 1)) ?
                          4'h0 : st_r.scan_idx + 4'h1;
      end
      else
        st_nxt.dwell = st_r.dwell + 16'h1;
      st_nxt.drive.grid = '0;
      st_nxt.drive.grid[st_r.scan_idx] = 1'b1;
      st_nxt.drive.anode = disp_mem[st_r.scan_idx];
    end
  end

  // Display memory, written during the fill only
  always_ff @(posedge ref_clk)
  begin
    if (mem_we)
      disp_mem[st_r.addr] <= mem_wdata;
  end

  // State register; ready stays high through reset
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      st_r <= '0;
      // Key stages start at the idle level; no phantom press after reset
      st_r.key_s1 <= '1;
      st_r.key_s2 <= '1;
      st_r.state <= ST_STRAP;
      st_r.ready_n <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  // Outputs straight from flops
  assign ctrl_rx_ready = st_r.ready_n;
  assign controller_clock_half = st_r.half_clk;
  assign cmd_out = st_r.cmd;
  assign panel_out = st_r.drive;
  assign beeper = st_r.beep;
  assign key_pressed = st_r.keys;

endmodule : vfd_display_controller

/* File: shared/vfd_pkg.sv */
package vfd_pkg;

  // Display geometry
  localparam int GRID_COUNT   = 11;
  localparam int ANODE_COUNT  = 16;
  localparam int SCAN_LINES   = 6;
  localparam int ADDR_W       = 4;

  // Clock figures: host display clock and the halved controller rate
  localparam int SYS_CLK_KHZ  = 100000;
  localparam int HOST_CLK_KHZ = 1024;
  localparam int CTRL_CLK_KHZ = 512;
  // Cycles of ref_clk per half period of the controller clock
  localparam int HALF_DIV_CYC = SYS_CLK_KHZ / (2 * CTRL_CLK_KHZ);
  localparam logic [7:0] HALF_DIV_LAST = 8'(HALF_DIV_CYC - 1);

  // Grid dwell time and beeper time
  localparam int GRID_DWELL_US = 100;
  localparam int GRID_DWELL_CYC = GRID_DWELL_US * SYS_CLK_KHZ / 1000;
  localparam int BEEP_MS = 200;
  localparam int BEEP_CYC = BEEP_MS * SYS_CLK_KHZ;

  // Anode pattern words, written to the display memory during the fill
  localparam logic [15:0] ANODE_ALL_ON  = 16'hffff;
  localparam logic [15:0] ANODE_ALL_OFF = 16'h0000;
  localparam logic [15:0] TEST1_EVEN    = 16'haaaa;
  localparam logic [15:0] TEST1_ODD     = 16'h5555;
  localparam logic [15:0] TEST2_EVEN    = 16'hff00;
  localparam logic [15:0] TEST2_ODD     = 16'h00ff;

  // Power-up pattern, decoded from the two straps
  typedef enum logic [1:0] {
    PAT_ALL_OFF = 2'h0,
    PAT_ALL_ON  = 2'h1,
    PAT_TEST1   = 2'h2,
    PAT_TEST2   = 2'h3
  } pattern_type;

  // Controller sequence, one-hot
  typedef enum logic [3:0] {
    ST_STRAP = 4'b0001,
    ST_FILL  = 4'b0010,
    ST_READY = 4'b0100,
    ST_IDLE  = 4'b1000
  } state_type;

  // Front-panel drive bundle
  typedef struct packed {
    logic [GRID_COUNT-1:0]  grid;
    logic [ANODE_COUNT-1:0] anode;
  } panel_drive_type;

  // One received command byte
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } cmd_type;

endpackage : vfd_pkg

/* File: dv/vfd_host_model.sv */
`timescale 1ns/1ps
module vfd_host_model
(
  // Bench clock
  input  wire logic ref_clk,
  // Link toward the controller
  output logic      host_display_clock,
  output logic      host_cmd_data,
  output logic      host_cmd_clock
);
  // Free-running 1.024 MHz display clock
  initial
  begin
    host_display_clock = 1'b0;
    forever #488.281 host_display_clock = ~host_display_clock;
  end
  // Serial clock rests low outside frames
  initial
  begin
    host_cmd_clock = 1'b0;
    host_cmd_data  = 1'b1;
  end
  // Top n bits MSB first, each phase at least 4 cycles
  task automatic send_bits(input logic [7:0] v, input int n);
    for (int i = 7; i > 7 - n; i--)
    begin
      @(posedge ref_clk) #1 host_cmd_data = v[i];
      repeat (3) @(posedge ref_clk);
      #1 host_cmd_clock = 1'b1;
      repeat (4) @(posedge ref_clk);
      #1 host_cmd_clock = 1'b0;
    end
    // Released data shows the inverse, never a stale bit
    @(posedge ref_clk) #1 host_cmd_data = ~host_cmd_data;
  endtask : send_bits
endmodule : vfd_host_model

/* File: dv/vfd_display_controller_monitor.sv */
`timescale 1ns/1ps
module vfd_monitor
  import vfd_pkg::*;
(
  // Clock and reset
  input wire logic                      ref_clk,
  input wire logic                      reset,
  // Watched ports
  input wire logic                      pattern_sel_a_n,
  input wire logic                      ctrl_rx_ready,
  input wire logic                      controller_clock_half,
  input wire vfd_pkg::cmd_type          cmd_out,
  input wire vfd_pkg::panel_drive_type  panel_out,
  input wire logic                      beeper,
  input wire logic [SCAN_LINES-1:0]     key_scan_line,
  input wire logic [SCAN_LINES-1:0]     key_pressed
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  // Last grid word, for the rotation check
  logic [10:0] grid_r;
  always_ff @(posedge ref_clk)
    grid_r <= panel_out.grid;
  chk_rdy_release: assert property (
    $fell(reset) |-> ctrl_rx_ready ##[1:40] !ctrl_rx_ready)
    else $error("ready not high then low after reset");
  chk_rdy_stays: assert property (
    !ctrl_rx_ready |=> !ctrl_rx_ready)
    else $error("ready rose without reset");
  chk_grid_rotate: assert property (
    panel_out.grid != grid_r && !$past(ctrl_rx_ready)
    |-> panel_out.grid == {grid_r[9:0], grid_r[10]})
    else $error("grid scan out of order");
  chk_grid_dwell: assert property (
    panel_out.grid != grid_r && !$past(ctrl_rx_ready)
    |=> $stable(panel_out.grid)[*8])
    else $error("grid dwell too short");
  chk_half_clock: assert property (
    $changed(controller_clock_half)
    |=> $stable(controller_clock_half)[*8])
    else $error("controller clock toggles too fast");
  chk_key_map: assert property (
    $stable(key_scan_line)[*6] |-> key_pressed == ~key_scan_line)
    else $error("key lines not mirrored");
  chk_beep_cause: assert property (
    $rose(beeper) |-> !pattern_sel_a_n)
    else $error("beeper without test pattern");
  chk_cmd_pulse: assert property (
    cmd_out.valid |=> !cmd_out.valid)
    else $error("command valid longer than one cycle");
  chk_cmd_gated: assert property (
    cmd_out.valid |-> !ctrl_rx_ready)
    else $error("command before ready");
  chk_key_after_reset: assert property (
    $fell(reset) |=> (key_pressed == 6'h00)[*2])
    else $error("phantom key press after reset");
  chk_half_after_reset: assert property (
    $fell(reset) |-> (controller_clock_half == 1'b0)[*4])
    else $error("controller clock toggled during strap sampling");
endmodule : vfd_monitor
bind vfd_display_controller vfd_monitor mon (
  .ref_clk(ref_clk), .reset(reset), .pattern_sel_a_n(pattern_sel_a_n),
  .ctrl_rx_ready(ctrl_rx_ready),
  .controller_clock_half(controller_clock_half), .cmd_out(cmd_out),
  .panel_out(panel_out), .beeper(beeper),
  .key_scan_line(key_scan_line), .key_pressed(key_pressed));

/* File: dv/test_vfd_display_controller.sv */
`timescale 1ns/1ps
module test_vfd_display_controller;
  import vfd_pkg::*;
  logic            ref_clk, reset, sel_a_n, sel_b_n, beep;
  logic            hdclk, cdata, cclk, rdy, half;
  logic [5:0]      keys, pressed;
  logic [7:0]      last_cmd;
  cmd_type         cmd;
  panel_drive_type panel;
  int              errors, total_checks, n_cmd;
  vfd_host_model host (.ref_clk(ref_clk), .host_display_clock(hdclk),
    .host_cmd_data(cdata), .host_cmd_clock(cclk));
  vfd_display_controller dut (.ref_clk(ref_clk), .reset(reset),
    .pattern_sel_a_n(sel_a_n), .pattern_sel_b_n(sel_b_n),
    .host_display_clock(hdclk), .host_cmd_data(cdata),
    .host_cmd_clock(cclk), .ctrl_rx_ready(rdy),
    .controller_clock_half(half), .cmd_out(cmd), .panel_out(panel),
    .beeper(beep), .key_scan_line(keys), .key_pressed(pressed));
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Capture every received byte; the pulse lasts one cycle
  always @(posedge ref_clk)
    if (cmd.valid === 1'b1)
    begin
      last_cmd <= cmd.data;
      n_cmd <= n_cmd + 1;
    end
  task automatic check(input logic ok, input string what);
    total_checks++;
    if (ok !== 1'b1)
    begin
      errors++;
      $display("BAD %0t %s", $time, what);
    end
  endtask : check
  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test
  task automatic do_reset(input logic a, input logic b);
    @(posedge ref_clk) #1 reset = 1'b1;
    sel_a_n = a;
    sel_b_n = b;
    repeat (4) @(posedge ref_clk);
    check(rdy === 1'b1 && panel === '0 && beep === 1'b0, "reset");
    #1 reset = 1'b0;
  endtask : do_reset
  // Bounded wait for the active-low ready
  task automatic wait_ready;
    for (int n = 0; n < 100 && rdy !== 1'b0; n++)
      @(posedge ref_clk);
    check(rdy === 1'b0, "ready never fell");
  endtask : wait_ready
  task automatic test_power_up(input logic a, b,
    input logic [15:0] e0, e1, input logic bp);
    do_reset(a, b);
    wait_ready();
    @(posedge ref_clk) #1;
    check(panel.grid === 11'h001 && panel.anode === e0, "grid0");
    check(beep === bp, "beeper");
    for (int n = 0; n < 10100 && panel.grid === 11'h001; n++)
      @(posedge ref_clk);
    #1 check(panel.grid === 11'h002 && panel.anode === e1, "grid1");
  endtask : test_power_up
  // A stray bit before ready must not shift the first byte
  task automatic test_commands;
    int base;
    do_reset(1'b1, 1'b0);
    host.send_bits(8'h80, 1);
    wait_ready();
    base = n_cmd;
    host.send_bits(8'h5a, 8);
    repeat (10) @(posedge ref_clk);
    check(last_cmd === 8'h5a && n_cmd == base + 1, "first byte");
    host.send_bits(8'h81, 8);
    repeat (10) @(posedge ref_clk);
    check(last_cmd === 8'h81 && n_cmd == base + 2, "second byte");
  endtask : test_commands
  task automatic test_keys;
    for (int i = 0; i < SCAN_LINES; i++)
    begin
      @(posedge ref_clk) #1 keys = ~(6'h01 << i);
      repeat (6) @(posedge ref_clk);
      #1 check(pressed === (6'h01 << i), "key");
    end
    @(posedge ref_clk) #1 keys = 6'h3f;
    repeat (6) @(posedge ref_clk);
    #1 check(pressed === 6'h00, "keys idle");
  endtask : test_keys
  // Halved clock: same after two host edges, flipped after three
  task automatic test_half_clock;
    logic h;
    @(negedge hdclk) h = half;
    repeat (2) @(negedge hdclk);
    check(half === h, "half clock even");
    @(negedge hdclk);
    check(half === ~h, "half clock odd");
  endtask : test_half_clock
  initial
  begin
    reset = 1'b1;
    sel_a_n = 1'b1;
    sel_b_n = 1'b0;
    keys = 6'h3f;
    test_power_up(1'b1, 1'b1, ANODE_ALL_OFF, ANODE_ALL_OFF, 1'b0);
    test_power_up(1'b1, 1'b0, ANODE_ALL_ON, ANODE_ALL_ON, 1'b0);
    test_power_up(1'b0, 1'b1, TEST1_EVEN, TEST1_ODD, 1'b1);
    test_power_up(1'b0, 1'b0, TEST2_EVEN, TEST2_ODD, 1'b1);
    test_commands();
    test_keys();
    test_half_clock();
    finish_test();
  end
  // Watchdog: whole run needs about two fifths of this
  initial
  begin
    #1000000;
    errors++;
    $display("BAD %0t watchdog", $time);
    finish_test();
  end
endmodule : test_vfd_display_controller
